// ### design/link_control_config_registers.sv
// link control and line configuration registers behind an APB slave
//
// Operation
// - control bit 7 enables serial link; its reset value comes from straps.
// - reverse channel unusable for 500 us after link start or stop.
// - control bit 4 set puts the device to sleep, clear runs normally.
// - sleep reset value derived from data-select pin and straps.
// - bits 3:2 pick I2C (00) or UART (01) base interface; reset 00.
// - interface codes 10 and 11 switch the local control channel off.
// - control bit 1 gates reverse channel reception; reset 1.
// - control bit 0 gates forward channel transmission; reset 1.
// - configuration bit 7 drops register address in UART-to-I2C conversion.
// - configuration bits 5:4 pick output swing 100 to 400 mV; reset 11.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module link_control_config_registers
#(
  parameter int REVERSE_QUIET_CYCLES = link_cfg_pkg::REVERSE_QUIET_CYCLES
)
(
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [link_cfg_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [link_cfg_pkg::DATA_W-1:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [link_cfg_pkg::DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // strap and mode pins
  input wire logic [1:0] I_CONFIG_STRAP_PINS,
  input wire logic I_CONTROL_DATA_SELECT_PIN,
  input wire logic I_INTERFACE_SELECT_PIN,
  // link control
  output logic O_SERIAL_LINK_ENABLE,
  output logic O_SLEEP,
  output logic O_LOCAL_IF_I2C,
  output logic O_LOCAL_IF_UART,
  output logic O_LOCAL_CHANNEL_OFF,
  output logic O_REVERSE_RX_ENABLE,
  output logic O_FORWARD_TX_ENABLE,
  output logic O_REVERSE_QUIET,
  // line configuration
  output logic O_CONVERSION_METHOD,
  output logic O_JITTER_FILTER_OFF,
  output logic [1:0] O_OUTPUT_SWING_LEVEL,
  output logic [3:0] O_EMPHASIS_CODE
);

  // ************************************************************
  // strap decoding
  // ************************************************************

  // link runs from power-up when the upper strap is high
  function automatic logic strap_link_on(input logic [1:0] strap);
    strap_link_on = strap[1];
  endfunction

  // sleep from power-up when control data is selected and link is off
  function automatic logic strap_sleep(input logic [1:0] strap, input logic control_data_select_pin);
    strap_sleep = control_data_select_pin & !strap_link_on(strap);
  endfunction

  // interface code that disables the local control channel
  function automatic logic if_code_off(input logic [1:0] code);
    if_code_off = code[1];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  link_cfg_pkg::link_control_s link_control;
  link_cfg_pkg::link_control_s next_link_control;
  link_cfg_pkg::line_configuration_s line_configuration;
  link_cfg_pkg::line_configuration_s next_line_configuration;
  link_cfg_pkg::bus_state_e bus_state;
  link_cfg_pkg::bus_state_e next_bus_state;
  logic [link_cfg_pkg::DATA_W-1:0] next_prdata;
  logic quiet_busy;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire logic access_phase;
  wire logic bus_complete;
  wire logic hit_link_control;
  wire logic hit_line_configuration;
  wire logic hit_any;
  wire logic lane0_write;
  wire logic write_link_control;
  wire logic write_line_configuration;
  wire logic [link_cfg_pkg::REG_W-1:0] wbyte;
  wire logic [link_cfg_pkg::REG_W-1:0] link_control_word;
  wire logic [link_cfg_pkg::REG_W-1:0] line_configuration_word;
  wire logic [link_cfg_pkg::REG_W-1:0] read_byte;
  wire logic link_toggle;

  assign access_phase = I_PSEL & I_PENABLE;
  assign bus_complete = access_phase & (bus_state == link_cfg_pkg::BUS_DONE);
  assign hit_link_control = (I_PADDR == link_cfg_pkg::ADDR_LINK_CONTROL);
  assign hit_line_configuration = (I_PADDR == link_cfg_pkg::ADDR_LINE_CONFIGURATION);
  assign hit_any = hit_link_control | hit_line_configuration;
  assign lane0_write = bus_complete & I_PWRITE & I_PSTRB[0];
  assign write_link_control = lane0_write & hit_link_control;
  assign write_line_configuration = lane0_write & hit_line_configuration;
  assign wbyte = I_PWDATA[link_cfg_pkg::REG_W-1:0];

  // ************************************************************
  // read view; bits 6 and 5 of link control read as zero
  // ************************************************************
  assign link_control_word = {
    link_control.serial_link_enable,
    2'h0,
    link_control.sleep,
    link_control.local_interface_type,
    link_control.reverse_channel_enable,
    link_control.forward_channel_enable
  };

  assign line_configuration_word = {
    line_configuration.conversion_method,
    line_configuration.jitter_filter_off,
    line_configuration.output_swing_level,
    line_configuration.emphasis_code
  };

  assign read_byte = hit_link_control ? link_control_word :
    hit_line_configuration ? line_configuration_word :
    8'h00;

  // ************************************************************
  // bus sequencing: one wait state, then pready
  // ************************************************************
  always_comb
  begin
    next_bus_state = bus_state;
    next_prdata = O_PRDATA;
    unique case (bus_state)
      link_cfg_pkg::BUS_IDLE:
      begin
        if (access_phase)
        begin
          next_bus_state = link_cfg_pkg::BUS_DONE;
          next_prdata = {24'h000000, read_byte};
        end
      end
      link_cfg_pkg::BUS_DONE:
      begin
        next_bus_state = link_cfg_pkg::BUS_IDLE;
      end
      default:
      begin
        next_bus_state = link_cfg_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      bus_state <= link_cfg_pkg::BUS_IDLE;
      O_PRDATA <= 32'h00000000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else if (I_CE)
    begin
      bus_state <= next_bus_state;
      O_PRDATA <= next_prdata;
      O_PREADY <= (next_bus_state == link_cfg_pkg::BUS_DONE);
      O_PSLVERR <= (next_bus_state == link_cfg_pkg::BUS_DONE) & !hit_any;
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_comb
  begin
    next_link_control = link_control;
    next_line_configuration = line_configuration;
    if (write_link_control)
    begin
      next_link_control.serial_link_enable = wbyte[link_cfg_pkg::POS_SERIAL_LINK_ENABLE];
      next_link_control.sleep = wbyte[link_cfg_pkg::POS_SLEEP];
      next_link_control.local_interface_type = wbyte[link_cfg_pkg::POS_LOCAL_IF_LO +: 2];
      next_link_control.reverse_channel_enable = wbyte[link_cfg_pkg::POS_REVERSE_CH];
      next_link_control.forward_channel_enable = wbyte[link_cfg_pkg::POS_FORWARD_CH];
    end
    if (write_line_configuration)
    begin
      next_line_configuration.conversion_method = wbyte[link_cfg_pkg::POS_CONVERSION];
      next_line_configuration.jitter_filter_off = wbyte[link_cfg_pkg::POS_JITTER_OFF];
      next_line_configuration.output_swing_level = wbyte[link_cfg_pkg::POS_SWING_LO +: 2];
      next_line_configuration.emphasis_code = wbyte[link_cfg_pkg::POS_EMPHASIS_LO +: 4];
    end
  end

  // straps are sampled by the clock while reset is held
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      link_control.serial_link_enable <= strap_link_on(I_CONFIG_STRAP_PINS);
      link_control.sleep <= strap_sleep(I_CONFIG_STRAP_PINS, I_CONTROL_DATA_SELECT_PIN);
      link_control.local_interface_type <= link_cfg_pkg::RST_LOCAL_IF;
      link_control.reverse_channel_enable <= link_cfg_pkg::RST_REVERSE_CH;
      link_control.forward_channel_enable <= link_cfg_pkg::RST_FORWARD_CH;
      line_configuration.conversion_method <= link_cfg_pkg::RST_CONVERSION;
      line_configuration.jitter_filter_off <= link_cfg_pkg::RST_JITTER_OFF;
      line_configuration.output_swing_level <= link_cfg_pkg::RST_SWING;
      line_configuration.emphasis_code <= link_cfg_pkg::RST_EMPHASIS;
    end
    else if (I_CE)
    begin
      link_control <= next_link_control;
      line_configuration <= next_line_configuration;
    end
  end

  // ************************************************************
  // reverse channel hold-off after link start or stop
  // ************************************************************
  assign link_toggle = write_link_control &
    (wbyte[link_cfg_pkg::POS_SERIAL_LINK_ENABLE] != link_control.serial_link_enable);

  quiet_timer
  #(
    .CYCLES(REVERSE_QUIET_CYCLES)
  )
  u_quiet_timer
  (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_ce(I_CE),
    .i_start(link_toggle),
    .o_busy(quiet_busy)
  );

  // ************************************************************
  // control outputs
  // ************************************************************
  wire logic local_base_mode;
  wire logic local_off;
  wire logic next_reverse_rx;

  assign local_base_mode = !I_INTERFACE_SELECT_PIN & I_CONTROL_DATA_SELECT_PIN;
  assign local_off = if_code_off(next_link_control.local_interface_type);
  assign next_reverse_rx = next_link_control.reverse_channel_enable &
    !(quiet_busy | link_toggle);

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_SERIAL_LINK_ENABLE <= 1'b0;
      O_SLEEP <= 1'b0;
      O_LOCAL_IF_I2C <= 1'b0;
      O_LOCAL_IF_UART <= 1'b0;
      O_LOCAL_CHANNEL_OFF <= 1'b0;
      O_REVERSE_RX_ENABLE <= 1'b0;
      O_FORWARD_TX_ENABLE <= 1'b0;
      O_REVERSE_QUIET <= 1'b0;
      O_CONVERSION_METHOD <= 1'b0;
      O_JITTER_FILTER_OFF <= 1'b0;
      O_OUTPUT_SWING_LEVEL <= 2'h0;
      O_EMPHASIS_CODE <= 4'h0;
    end
    else if (I_CE)
    begin
      O_SERIAL_LINK_ENABLE <= next_link_control.serial_link_enable;
      O_SLEEP <= next_link_control.sleep;
      O_LOCAL_IF_I2C <= local_base_mode & !local_off &
        (next_link_control.local_interface_type == link_cfg_pkg::LOCAL_IF_I2C);
      O_LOCAL_IF_UART <= local_base_mode & !local_off &
        (next_link_control.local_interface_type == link_cfg_pkg::LOCAL_IF_UART);
      O_LOCAL_CHANNEL_OFF <= local_off;
      O_REVERSE_RX_ENABLE <= next_reverse_rx;
      O_FORWARD_TX_ENABLE <= next_link_control.forward_channel_enable;
      O_REVERSE_QUIET <= quiet_busy | link_toggle;
      O_CONVERSION_METHOD <= next_line_configuration.conversion_method;
      O_JITTER_FILTER_OFF <= next_line_configuration.jitter_filter_off;
      O_OUTPUT_SWING_LEVEL <= next_line_configuration.output_swing_level;
      O_EMPHASIS_CODE <= next_line_configuration.emphasis_code;
    end
  end

endmodule // link_control_config_registers

`default_nettype wire

// ### design/link_cfg_pkg.sv
// constants and types shared by the link configuration register bank
package link_cfg_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // printed offsets are register indices; byte address is four times that
  localparam logic [ADDR_W-1:0] IDX_LINK_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] IDX_LINE_CONFIGURATION = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_LINK_CONTROL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CONFIGURATION = 8'h14;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_SERIAL_LINK_ENABLE = 7;
  localparam int POS_SLEEP = 4;
  localparam int POS_LOCAL_IF_LO = 2;
  localparam int POS_REVERSE_CH = 1;
  localparam int POS_FORWARD_CH = 0;
  localparam int POS_CONVERSION = 7;
  localparam int POS_JITTER_OFF = 6;
  localparam int POS_SWING_LO = 4;
  localparam int POS_EMPHASIS_LO = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0] RST_LOCAL_IF = 2'h0;
  localparam logic RST_REVERSE_CH = 1'b1;
  localparam logic RST_FORWARD_CH = 1'b1;
  localparam logic RST_CONVERSION = 1'b0;
  localparam logic RST_JITTER_OFF = 1'b1;
  localparam logic [1:0] RST_SWING = 2'h3;
  localparam logic [3:0] RST_EMPHASIS = 4'h0;

  // local interface codes
  localparam logic [1:0] LOCAL_IF_I2C = 2'h0;
  localparam logic [1:0] LOCAL_IF_UART = 2'h1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int REVERSE_QUIET_US = 500;
  localparam int REVERSE_QUIET_CYCLES = REVERSE_QUIET_US * (CLK_HZ / 1_000_000);
  localparam int QUIET_CNT_W = 16;

  // ************************************************************
  // register contents
  // ************************************************************
  typedef struct packed {
    logic serial_link_enable;
    logic sleep;
    logic [1:0] local_interface_type;
    logic reverse_channel_enable;
    logic forward_channel_enable;
  } link_control_s;

  typedef struct packed {
    logic conversion_method;
    logic jitter_filter_off;
    logic [1:0] output_swing_level;
    logic [3:0] emphasis_code;
  } line_configuration_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_e;

endpackage

// ### design/quiet_timer.sv
// one-shot hold-off timer that runs a fixed number of cycles after a start pulse
`timescale 1ns/1ps
`default_nettype none

module quiet_timer
#(
  parameter int CYCLES = 5000
)
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // control
  input wire logic i_start,
  // status
  output logic o_busy
);

  localparam logic [link_cfg_pkg::QUIET_CNT_W-1:0] LAST =
    link_cfg_pkg::QUIET_CNT_W'(CYCLES - 1);

  logic [link_cfg_pkg::QUIET_CNT_W-1:0] count;
  logic [link_cfg_pkg::QUIET_CNT_W-1:0] next_count;
  logic next_busy;
  wire logic at_end;

  assign at_end = (count == LAST);

  // a new start restarts the full interval
  always_comb
  begin
    next_count = count;
    next_busy = o_busy;
    if (i_start)
    begin
      next_count = '0;
      next_busy = 1'b1;
    end
    else if (o_busy)
    begin
      next_count = count + 1'b1;
      next_busy = !at_end;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      count <= '0;
      o_busy <= 1'b0;
    end
    else if (i_ce)
    begin
      count <= next_count;
      o_busy <= next_busy;
    end
  end

endmodule // quiet_timer

`default_nettype wire

// ### bench/link_cfg_props.sv
// assertion checker for the link configuration register bank
`timescale 1ns/1ps
`default_nettype none

module link_cfg_props
#(
  parameter int REVERSE_QUIET_CYCLES = 8
)
(
  // clock, reset, bus
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic [link_cfg_pkg::DATA_W-1:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // pins and controls
  input wire logic I_CONTROL_DATA_SELECT_PIN,
  input wire logic I_INTERFACE_SELECT_PIN,
  input wire logic O_SERIAL_LINK_ENABLE,
  input wire logic O_LOCAL_IF_I2C,
  input wire logic O_LOCAL_IF_UART,
  input wire logic O_LOCAL_CHANNEL_OFF,
  input wire logic O_REVERSE_RX_ENABLE,
  input wire logic O_REVERSE_QUIET
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  // ************************************************************
  // hold-off length counter, restarted by a link change
  // ************************************************************
  logic [15:0] quiet_cnt;
  logic link_q;
  always_ff @(posedge I_CLK)
  begin
    link_q <= O_SERIAL_LINK_ENABLE;
    if (I_SRST || !O_REVERSE_QUIET)
      quiet_cnt <= 16'h0000;
    else if (O_SERIAL_LINK_ENABLE != link_q)
      quiet_cnt <= 16'h0001;
    else if (I_CE)
      quiet_cnt <= quiet_cnt + 16'h0001;
  end

  property p_ready_time;
    I_PSEL && I_PENABLE && I_CE && !O_PREADY |=> O_PREADY;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready late");
  property p_ready_pulse;
    O_PREADY |=> !O_PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_ready;
    O_PSLVERR |-> O_PREADY;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_upper;
    O_PREADY |-> O_PRDATA[31:8] == 24'h000000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
  property p_local_off;
    O_LOCAL_CHANNEL_OFF |-> !(O_LOCAL_IF_I2C || O_LOCAL_IF_UART);
  endproperty
  a_local_off: assert property (p_local_off) else $error("channel off yet interface on");
  property p_if_gate;
    O_LOCAL_IF_I2C || O_LOCAL_IF_UART |-> $past(!I_INTERFACE_SELECT_PIN && I_CONTROL_DATA_SELECT_PIN);
  endproperty
  a_if_gate: assert property (p_if_gate) else $error("interface on with wrong pins");
  property p_rx_gate;
    O_REVERSE_RX_ENABLE |-> !O_REVERSE_QUIET;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("reverse rx during hold-off");
  property p_quiet_start;
    O_SERIAL_LINK_ENABLE != link_q && !$past(I_SRST, 2) |-> O_REVERSE_QUIET;
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("no hold-off on link change");
  property p_quiet_len;
    $fell(O_REVERSE_QUIET) |-> quiet_cnt == 16'(REVERSE_QUIET_CYCLES + 1);
  endproperty
  a_quiet_len: assert property (p_quiet_len) else $error("hold-off length wrong");
endmodule // link_cfg_props

bind link_control_config_registers link_cfg_props #(.REVERSE_QUIET_CYCLES(REVERSE_QUIET_CYCLES)) i_link_cfg_props
(
  .I_CLK(I_CLK),
  .I_SRST(I_SRST),
  .I_CE(I_CE),
  .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE),
  .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR),
  .I_CONTROL_DATA_SELECT_PIN(I_CONTROL_DATA_SELECT_PIN),
  .I_INTERFACE_SELECT_PIN(I_INTERFACE_SELECT_PIN),
  .O_SERIAL_LINK_ENABLE(O_SERIAL_LINK_ENABLE),
  .O_LOCAL_IF_I2C(O_LOCAL_IF_I2C),
  .O_LOCAL_IF_UART(O_LOCAL_IF_UART),
  .O_LOCAL_CHANNEL_OFF(O_LOCAL_CHANNEL_OFF),
  .O_REVERSE_RX_ENABLE(O_REVERSE_RX_ENABLE),
  .O_REVERSE_QUIET(O_REVERSE_QUIET)
);

`default_nettype wire

// ### bench/tb_top.sv
// self-checking testbench for the link configuration register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int QC = 8;
  logic clk, srst, ce, psel, penable, pwrite, control_data_select_pin, ifsel, ready, err, e;
  logic [7:0] paddr, lk_o, ln_o, d;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, emph;
  logic [1:0] straps, swing;
  logic link_en, sleep, if_i2c, if_uart, if_off, rx_en, tx_en, quiet, conv, jit;
  int n_fail = 0;
  int checks_done = 0;

  assign lk_o = {link_en, sleep, if_i2c, if_uart, if_off, rx_en, tx_en, quiet};
  assign ln_o = {conv, jit, swing, emph};

  link_control_config_registers #(.REVERSE_QUIET_CYCLES(QC)) i_link_control_config_registers
  (
    .I_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(ready),
    .O_PSLVERR(err), .I_CONFIG_STRAP_PINS(straps), .I_CONTROL_DATA_SELECT_PIN(control_data_select_pin),
    .I_INTERFACE_SELECT_PIN(ifsel), .O_SERIAL_LINK_ENABLE(link_en), .O_SLEEP(sleep),
    .O_LOCAL_IF_I2C(if_i2c), .O_LOCAL_IF_UART(if_uart), .O_LOCAL_CHANNEL_OFF(if_off),
    .O_REVERSE_RX_ENABLE(rx_en), .O_FORWARD_TX_ENABLE(tx_en), .O_REVERSE_QUIET(quiet),
    .O_CONVERSION_METHOD(conv), .O_JITTER_FILTER_OFF(jit), .O_OUTPUT_SWING_LEVEL(swing),
    .O_EMPHASIS_CODE(emph)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait that never gets ready
    while (ready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    e = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'hF);
    check(rd, exp);
    check(e, 1'b0);
  endtask

  task automatic do_reset(input logic [1:0] s, input logic c);
    @(posedge clk);
    srst <= 1'b1;
    straps <= s;
    control_data_select_pin <= c;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // outputs leave their reset zeros at the first edge after release
    repeat (2) @(negedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    do_reset(2'b10, 1'b1);
    check(lk_o, 8'hA6);
    check(ln_o, 8'h70);
    rdchk(8'h10, 32'h0000_0083);
    rdchk(8'h14, 32'h0000_0070);
    do_reset(2'b00, 1'b1);
    check(lk_o, 8'h66);
    rdchk(8'h10, 32'h0000_0013);
    $display("t_reset done");
  endtask

  task automatic t_codes;
    for (int i = 0; i < 4; i++)
    begin
      d = {1'b0, 2'b11, i[0], i[1:0], ~i[1], i[0]};
      apb(1'b1, 8'h10, {24'h000000, d}, 4'hF);
      @(negedge clk);
      check(lk_o, {1'b0, i[0], i == 0, i == 1, i[1], ~i[1], i[0], 1'b0});
      rdchk(8'h10, {24'h000000, d & 8'h9F});
    end
    apb(1'b1, 8'h10, 32'h0000_0003, 4'hF);
    @(negedge clk);
    check(if_i2c, 1'b1);
    @(posedge clk);
    ifsel <= 1'b1;
    repeat (2) @(negedge clk);
    check(if_i2c, 1'b0);
    @(posedge clk);
    ifsel <= 1'b0;
    control_data_select_pin <= 1'b0;
    repeat (2) @(negedge clk);
    check(if_i2c, 1'b0);
    @(posedge clk);
    control_data_select_pin <= 1'b1;
    $display("t_codes done");
  endtask

  task automatic t_quiet;
    apb(1'b1, 8'h10, 32'h0000_0083, 4'hF);
    @(negedge clk);
    check({link_en, quiet, rx_en}, 3'b110);
    repeat (QC) @(negedge clk);
    check(quiet, 1'b1);
    @(negedge clk);
    check({quiet, rx_en}, 2'b01);
    apb(1'b1, 8'h10, 32'h0000_0083, 4'hF);
    @(negedge clk);
    check(quiet, 1'b0);
    apb(1'b1, 8'h10, 32'h0000_0003, 4'hF);
    apb(1'b1, 8'h10, 32'h0000_0083, 4'hF);
    @(negedge clk);
    repeat (QC) @(negedge clk);
    check({link_en, quiet, rx_en}, 3'b110);
    @(negedge clk);
    check({quiet, rx_en}, 2'b01);
    $display("t_quiet done");
  endtask

  task automatic t_line;
    for (int i = 0; i < 4; i++)
    begin
      d = {i[0], i[1], i[1:0], 4'h5 + 4'(i)};
      apb(1'b1, 8'h14, {24'h000000, d}, 4'hF);
      @(negedge clk);
      check(ln_o, d);
      rdchk(8'h14, {24'h000000, d});
    end
    $display("t_line done");
  endtask

  task automatic t_errors;
    apb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    check(e, 1'b1);
    apb(1'b1, 8'h18, 32'h0000_00FF, 4'hF);
    check(e, 1'b1);
    apb(1'b1, 8'h14, 32'h0000_0000, 4'h0);
    check(e, 1'b0);
    rdchk(8'h14, {24'h000000, d});
    fork
      rdchk(8'h10, 32'h0000_0083);
      begin
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    $display("t_errors done");
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    end_sim;
  end

  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    straps = 2'b10;
    control_data_select_pin = 1'b1;
    ifsel = 1'b0;
    t_reset;
    t_codes;
    t_quiet;
    t_line;
    t_errors;
    end_sim;
  end
endmodule // tb_top

`default_nettype wire
